// File: rtl/jsfr_framer.sv
// 64b/66b framer with prefix stream, crc-12 and block fifo
`timescale 1ns/1ps
`include "jsfr_cfg.svh"

module jsfr_fifo #(
  parameter int W = 64,
  parameter int D = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  output logic [W-1:0]      rd_data_o,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          rdy_ff;
  logic          push;
  logic          pop;

  assign push       = wr_valid_i & rdy_ff;
  assign pop        = rd_valid_o & rd_ready_i;
  assign rd_valid_o = (cnt_ff != '0);
  assign rd_data_o  = mem_ff[rptr_ff];
  assign wr_ready_o = rdy_ff;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (push && !pop)
      nxt_cnt = cnt_ff + 1'b1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      // ready held in a flop so the top port is registered
      rdy_ff <= (nxt_cnt != (AW+1)'(D));
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      if (push)
        wptr_ff <= (wptr_ff == AW'(D-1)) ? '0 : wptr_ff + 1'b1;
      if (pop)
        rptr_ff <= (rptr_ff == AW'(D-1)) ? '0 : rptr_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_ff[wptr_ff] <= wr_data_i;
  end
endmodule

module jsfr_framer #(
  parameter int FIFO_DEPTH = `JSFR_FIFO_DEPTH
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic [`JSFR_PAYLOAD_W-1:0]  payload_i,
  input  wire logic                        payload_valid_i,
  output logic                             payload_ready_o,
  input  wire jsfr_pkg::jsfr_cfg_t         cfg_i,
  input  wire logic [`JSFR_FEC_W-1:0]      fec_parity_i,
  input  wire logic                        sysref_i,
  output jsfr_pkg::jsfr_blk_t              blk_o,
  output logic                             blk_valid_o,
  input  wire logic                        blk_ready_i,
  output logic                             emb_start_o,
  output logic                             fmt_err_o
);

  logic [`JSFR_PAYLOAD_W-1:0] q_data;
  logic                       q_valid;
  logic                       q_ready;
  logic                       take;
  logic [`JSFR_BLK_IDX_W-1:0] blk_idx_ff;
  logic [`JSFR_MB_IDX_W-1:0]  mb_idx_ff;
  logic [`JSFR_MB_IDX_W-1:0]  last_mb;
  logic [`JSFR_CRC_W-1:0]     crc_ff;
  logic [`JSFR_CRC_W-1:0]     nxt_crc;
  logic [`JSFR_CRC_W-1:0]     crc_done_ff;
  logic [`JSFR_STREAM_W-1:0]  word_ff;
  logic [`JSFR_STREAM_W-1:0]  cur_word;
  logic                       sysref_d_ff;
  logic                       realign;
  logic                       stream_bit;

  // serial crc over one block, payload bit 0 enters first
  function automatic logic [`JSFR_CRC_W-1:0] crc_blk(
    input logic [`JSFR_CRC_W-1:0]    seed,
    input logic [`JSFR_PAYLOAD_W-1:0] d
  );
    logic [`JSFR_CRC_W-1:0] c;
    logic                   fb;
    c = seed;
    for (int i = 0; i < `JSFR_PAYLOAD_W; i++)
    begin
      fb = d[i] ^ c[`JSFR_CRC_W-1];
      c  = {c[`JSFR_CRC_W-2:0], 1'b0} ^
           (fb ? `JSFR_CRC_POLY : `JSFR_CRC_INIT);
    end
    return c;
  endfunction

  // builds the 32-bit prefix stream word of one multiblock
  function automatic logic [`JSFR_STREAM_W-1:0] build_word(
    input jsfr_pkg::jsfr_fmt_t    fmt,
    input logic [`JSFR_CRC_W-1:0] crc,
    input logic [`JSFR_FEC_W-1:0] fec,
    input logic                   emb_end
  );
    logic [`JSFR_STREAM_W-1:0] w;
    w = `JSFR_RST_STREAM;
    if (fmt == jsfr_pkg::JSFR_FMT_FEC)
    begin
      // parity msb rides in stream bit 0, so the order is reversed
      for (int i = 0; i < 22; i++)
        w[i] = fec[25-i];
      w[23]    = fec[3];
      w[24]    = fec[2];
      w[25]    = fec[1];
      w[26]    = fec[0];
    end
    else
    begin
      // fixed ones keep 00001 from forming early
      // check msb goes first, stream bit 0 holds crc bit 11
      w[0]     = crc[11];
      w[1]     = crc[10];
      w[2]     = crc[9];
      w[4]     = crc[8];
      w[5]     = crc[7];
      w[6]     = crc[6];
      w[8]     = crc[5];
      w[9]     = crc[4];
      w[10]    = crc[3];
      w[12]    = crc[2];
      w[13]    = crc[1];
      w[14]    = crc[0];
      w[3]     = 1'b1;
      w[7]     = 1'b1;
      w[11]    = 1'b1;
      w[15]    = 1'b1;
      w[19]    = 1'b1;
      w[21]    = 1'b1;
      w[23]    = 1'b1;
      w[18:16] = 3'h0;
      w[20]    = 1'b0;
      w[26:24] = 3'h0;
    end
    w[30:27] = 4'h0;
    w[31]    = 1'b1;
    w[`JSFR_EMB_END_BIT] = emb_end;
    return w;
  endfunction

  jsfr_fifo #(
    .W (`JSFR_PAYLOAD_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .wr_data_i  (payload_i),
    .wr_valid_i (payload_valid_i),
    .wr_ready_o (payload_ready_o),
    .rd_data_o  (q_data),
    .rd_valid_o (q_valid),
    .rd_ready_i (q_ready)
  );

  // output stage drains the fifo when its register is empty or the line side takes its block
  assign q_ready = !blk_valid_o || blk_ready_i;
  assign take    = q_valid && q_ready;
  assign realign = sysref_i && !sysref_d_ff;

  // zero count treated as one multiblock per extended multiblock
  assign last_mb = (cfg_i.mb_per_emb == 8'h00) ? 8'h00
                                               : cfg_i.mb_per_emb - 8'h01;

  always_comb
  begin
    cur_word = word_ff;
    if (blk_idx_ff == '0)
      cur_word = build_word(cfg_i.sync_header_format_select, crc_done_ff,
                            fec_parity_i, (mb_idx_ff == last_mb));
  end

  assign stream_bit = cur_word[blk_idx_ff];

  always_comb
  begin
    // check state restarts from zero at block 0
    if (blk_idx_ff == '0)
      nxt_crc = crc_blk(`JSFR_CRC_INIT, q_data);
    else
      nxt_crc = crc_blk(crc_ff, q_data);
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sysref_d_ff <= 1'b0;
    else
      sysref_d_ff <= sysref_i;
  end

  // block and multiblock counters form the extended multiblock clock
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      blk_idx_ff <= '0;
      mb_idx_ff  <= '0;
    end
    else if (realign)
    begin
      // a block taken in this cycle is dropped from the old phase
      blk_idx_ff <= '0;
      mb_idx_ff  <= '0;
    end
    else if (take)
    begin
      blk_idx_ff <= blk_idx_ff + 1'b1;
      if (blk_idx_ff == `JSFR_LAST_BLK)
        mb_idx_ff <= (mb_idx_ff >= last_mb) ? '0
                                            : mb_idx_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      crc_ff      <= `JSFR_CRC_INIT;
      crc_done_ff <= `JSFR_CRC_INIT;
      word_ff     <= `JSFR_RST_STREAM;
    end
    else if (take && !realign)
    begin
      crc_ff <= nxt_crc;
      if (blk_idx_ff == `JSFR_LAST_BLK)
        crc_done_ff <= nxt_crc;
      if (blk_idx_ff == '0)
        word_ff <= cur_word;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      blk_o       <= '0;
      blk_valid_o <= 1'b0;
      emb_start_o <= 1'b0;
    end
    else if (q_ready)
    begin
      blk_valid_o <= take && !realign;
      if (take && !realign)
      begin
        blk_o.payload <= q_data;
        blk_o.prefix  <= {stream_bit, ~stream_bit};
        emb_start_o   <= (blk_idx_ff == '0) && (mb_idx_ff == '0);
      end
      else
        emb_start_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fmt_err_o <= 1'b0;
    else
      fmt_err_o <= (cfg_i.sync_header_format_select != jsfr_pkg::JSFR_FMT_CRC12)
                && (cfg_i.sync_header_format_select != jsfr_pkg::JSFR_FMT_FEC);
  end

endmodule

// File: inc/jsfr_cfg.svh
// constants for the 64b/66b block framer
`ifndef JSFR_CFG_SVH
`define JSFR_CFG_SVH

`define JSFR_OCTETS_PER_BLK   8
`define JSFR_PAYLOAD_W        64
`define JSFR_PREFIX_W         2
`define JSFR_BLK_W            66
`define JSFR_BLKS_PER_MB      32
`define JSFR_BLK_IDX_W        5
`define JSFR_LAST_BLK         5'h1f
`define JSFR_MB_IDX_W         8
`define JSFR_CRC_W            12
`define JSFR_CRC_POLY         12'h987
`define JSFR_CRC_INIT         12'h000
`define JSFR_FEC_W            26
`define JSFR_STREAM_W         32
`define JSFR_EMB_END_BIT      22
`define JSFR_FMT_W            2
`define JSFR_FIFO_DEPTH       4
`define JSFR_RST_STREAM       32'h0000_0000

`endif

// File: inc/jsfr_pkg.sv
// types for the 64b/66b block framer
package jsfr_pkg;

  typedef enum logic [1:0] {
    JSFR_FMT_CRC12 = 2'b00,
    JSFR_FMT_RSVD1 = 2'b01,
    JSFR_FMT_FEC   = 2'b10,
    JSFR_FMT_RSVD3 = 2'b11
  } jsfr_fmt_t;

  // bit 0 of the vector is sent first on the line
  typedef struct packed {
    logic [63:0] payload;
    logic [1:0]  prefix;
  } jsfr_blk_t;

  typedef struct packed {
    jsfr_fmt_t   sync_header_format_select;
    logic [7:0]  mb_per_emb;
  } jsfr_cfg_t;

endpackage

// File: test/jsfr_sink.sv
// far-end sink model: uneven acceptance and prefix check
`timescale 1ns/1ps
module jsfr_sink (
  input  logic                mclk_i,
  input  logic                rstn_i,
  input  logic                hold_i,
  input  logic                blk_valid_i,
  input  jsfr_pkg::jsfr_blk_t blk_i,
  output logic                ready_o,
  output logic                bad_o
);
  logic [1:0] ph_ff;
  // a stall every third cycle keeps the output stage holding
  assign ready_o = !hold_i && ph_ff != 2'h2;
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      ph_ff <= 2'h0;
    else
      ph_ff <= ph_ff[1] ? 2'h0 : ph_ff + 2'h1;
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      bad_o <= 1'h0;
    else if (blk_valid_i && ready_o && blk_i.prefix[0] == blk_i.prefix[1])
      bad_o <= 1'h1;
endmodule

// File: test/jsfr_framer_assertions.sv
// port assertions for the block framer
`timescale 1ns/1ps
module jsfr_chk #(
  parameter int FIFO_DEPTH = 4
) (
  input logic                mclk_i,
  input logic                rstn_i,
  input logic                payload_valid_i,
  input logic                payload_ready_o,
  input jsfr_pkg::jsfr_cfg_t cfg_i,
  input jsfr_pkg::jsfr_blk_t blk_o,
  input logic                blk_valid_o,
  input logic                blk_ready_i,
  input logic                emb_start_o,
  input logic                fmt_err_o
);
  logic [4:0] idx_ff;
  logic [4:0] cur;
  logic       sync_ff;
  logic       acc;
  logic       crc;
  assign cur = emb_start_o ? 5'h0 : idx_ff;
  assign acc = blk_valid_o && blk_ready_i && (sync_ff || emb_start_o);
  assign crc = cfg_i.sync_header_format_select == jsfr_pkg::JSFR_FMT_CRC12;
  // position in the multiblock; emb start realigns it after sysref
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      {sync_ff, idx_ff} <= 6'h00;
    else if (blk_valid_o && blk_ready_i)
      {sync_ff, idx_ff} <= {sync_ff | emb_start_o, cur + 5'h1};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  prefix_legal_a: assert property (
    blk_valid_o |-> blk_o.prefix inside {2'h1, 2'h2}) else $error("prefix");
  blk_hold_a: assert property (
    blk_valid_o && !blk_ready_i |=> blk_valid_o && $stable(blk_o))
    else $error("block dropped");
  pilot_zero_a: assert property (
    acc && cur inside {[27:30]} |-> blk_o.prefix == 2'h1) else $error("pilot");
  pilot_one_a: assert property (
    acc && cur == 5'h1f |-> blk_o.prefix == 2'h2) else $error("pilot end");
  crc_ones_a: assert property (
    acc && crc && cur inside {3, 7, 11, 15, 19, 21, 23} |-> blk_o.prefix == 2'h2)
    else $error("fixed one");
  cmd_zero_a: assert property (
    acc && crc && cur inside {[16:18], 20, [24:26]} |-> blk_o.prefix == 2'h1)
    else $error("command bit");
  emb_single_a: assert property (
    acc && cur == 5'h16 && cfg_i.mb_per_emb <= 8'h01 |-> blk_o.prefix == 2'h2)
    else $error("emb flag");
  fmt_bad_a: assert property (
    cfg_i.sync_header_format_select[0] [*2] |-> fmt_err_o) else $error("fmt");
  fmt_good_a: assert property (
    !cfg_i.sync_header_format_select[0] [*2] |-> !fmt_err_o) else $error("fmt");
  cover property (acc && emb_start_o);
  cover property (payload_valid_i && !payload_ready_o);
  cover property (fmt_err_o);
endmodule
bind jsfr_framer jsfr_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_jsfr_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .payload_valid_i(payload_valid_i),
  .payload_ready_o(payload_ready_o), .cfg_i(cfg_i), .blk_o(blk_o),
  .blk_valid_o(blk_valid_o), .blk_ready_i(blk_ready_i),
  .emb_start_o(emb_start_o), .fmt_err_o(fmt_err_o));

// File: test/testbench.sv
// self-checking bench for the block framer
`timescale 1ns/1ps
module testbench;
  localparam int FD = 4;
  logic                mclk_i = 1'h0;
  logic                rstn_i = 1'h0;
  logic                sysref_i = 1'h0;
  logic                hold = 1'h0;
  logic                p_valid = 1'h0;
  logic [63:0]         p_data = 64'h0;
  logic [25:0]         fec = 26'h2a5c3e1;
  jsfr_pkg::jsfr_cfg_t cfg = '{jsfr_pkg::JSFR_FMT_CRC12, 8'h02};
  jsfr_pkg::jsfr_blk_t blk;
  jsfr_pkg::jsfr_blk_t qb[$];
  logic                qe[$];
  logic                p_ready, b_valid, b_ready, emb, ferr, bad;
  int                  errors = 0;
  int                  total_checks = 0;

  always #12.5 mclk_i = ~mclk_i;

  jsfr_framer #(.FIFO_DEPTH(FD)) i_jsfr_framer (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .payload_i(p_data),
    .payload_valid_i(p_valid), .payload_ready_o(p_ready), .cfg_i(cfg),
    .fec_parity_i(fec), .sysref_i(sysref_i), .blk_o(blk),
    .blk_valid_o(b_valid), .blk_ready_i(b_ready), .emb_start_o(emb),
    .fmt_err_o(ferr));
  jsfr_sink i_jsfr_sink (.mclk_i(mclk_i), .rstn_i(rstn_i), .hold_i(hold),
    .blk_valid_i(b_valid), .blk_i(blk), .ready_o(b_ready), .bad_o(bad));

  always @(posedge mclk_i)
    if (b_valid === 1'h1 && b_ready === 1'h1)
    begin
      qb.push_back(blk);
      qe.push_back(emb);
    end

  task chk(input logic [65:0] seen, input logic [65:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [63:0] pat(int k);
    return 64'h9e37_79b9_7f4a_7c15 * (k + 1);
  endfunction

  // serial check, payload bit 0 first, block 0 first
  function automatic logic [11:0] crc_blk(logic [11:0] c, logic [63:0] d);
    for (int i = 0; i < 64; i++)
      c = {c[10:0], 1'h0} ^ ((d[i] ^ c[11]) ? 12'h987 : 12'h000);
    return c;
  endfunction

  function automatic logic [31:0] word(logic [11:0] c, logic e);
    logic [31:0] w;
    w = {1'h1, 7'h00, 1'h1, e, 3'h5, 3'h0, 1'h1, c[0], c[1], c[2], 1'h1,
         c[3], c[4], c[5], 1'h1, c[6], c[7], c[8], 1'h1, c[9], c[10], c[11]};
    if (cfg.sync_header_format_select == jsfr_pkg::JSFR_FMT_FEC)
    begin
      w = {1'h1, 4'h0, fec[0], fec[1], fec[2], fec[3], e, 22'h0};
      for (int i = 0; i < 22; i++)
        w[i] = fec[25 - i];
    end
    return w;
  endfunction

  task send(input logic [63:0] v);
    p_data <= v;
    p_valid <= 1'h1;
    do @(posedge mclk_i); while (p_ready !== 1'h1);
  endtask

  // bounded wait; an empty pop yields x and fails the compare
  task automatic pop(output jsfr_pkg::jsfr_blk_t b, output logic e);
    repeat (200) if (qb.size() == 0) @(posedge mclk_i);
    b = qb.pop_front();
    e = qe.pop_front();
  endtask

  task automatic run(input int nm, input int e, input int base);
    jsfr_pkg::jsfr_blk_t b;
    logic                s;
    logic [11:0]         prev;
    logic [11:0]         cur;
    logic [31:0]         w;
    prev = 12'h000;
    fork
      begin
        for (int k = 0; k < nm * 32; k++)
          send(pat(base + k));
        p_valid <= 1'h0;
      end
      for (int m = 0; m < nm; m++)
      begin
        w = word(prev, m % e == e - 1);
        cur = 12'h000;
        for (int n = 0; n < 32; n++)
        begin
          pop(b, s);
          chk(b, {pat(base + m * 32 + n), w[n] ? 2'h2 : 2'h1});
          chk(s, m % e == 0 && n == 0);
          cur = crc_blk(cur, pat(base + m * 32 + n));
        end
        prev = cur;
      end
    join
  endtask

  task t_crc;
    run(3, 2, 0);
    chk(ferr, 1'h0);
    chk(bad, 1'h0);
    $display("crc stream test done");
  endtask

  task automatic t_fill;
    jsfr_pkg::jsfr_blk_t b;
    logic                s;
    int                  k;
    k = 0;
    cfg <= '{jsfr_pkg::JSFR_FMT_FEC, 8'h01};
    hold <= 1'h1;
    p_data <= pat(900);
    p_valid <= 1'h1;
    repeat (12)
    begin
      @(posedge mclk_i);
      if (p_ready === 1'h1)
        k++;
      p_data <= pat(900 + k);
    end
    p_valid <= 1'h0;
    chk(p_ready, 1'h0);
    chk(k >= FD, 1'h1);
    hold <= 1'h0;
    for (int i = 0; i < k; i++)
    begin
      pop(b, s);
      chk(b.payload, pat(900 + i));
    end
    sysref_i <= 1'h1;
    @(posedge mclk_i);
    sysref_i <= 1'h0;
    run(1, 1, 2000);
    $display("fill and realign test done");
  endtask

  task t_fmt;
    for (int f = 1; f < 4; f += 2)
    begin
      cfg <= '{jsfr_pkg::jsfr_fmt_t'(f), 8'h01};
      repeat (2) @(posedge mclk_i);
      chk(ferr, 1'h1);
    end
    cfg <= '{jsfr_pkg::JSFR_FMT_CRC12, 8'h01};
    repeat (2) @(posedge mclk_i);
    chk(ferr, 1'h0);
    $display("format test done");
  endtask

  initial
  begin
    repeat (3000) @(posedge mclk_i);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    rstn_i <= 1'h0;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'h1;
    @(posedge mclk_i);
    t_crc();
    t_fill();
    t_fmt();
    test_done();
  end
endmodule
